// ==== hdl/dcrs_sequencer.sv ====
module dcrs_sequencer (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cycle_start_strobe_n_i,
  input wire logic forced_refresh_request_i,
  input wire logic high_byte_enable_i,
  input wire logic low_address_bit_i,
  input wire logic external_wait_in_i,
  input wire logic cpu_system_clock_i,
  input wire logic chip_select_i,
  input wire logic one_wait_select_n_i,
  output logic upper_column_strobe_n_o,
  output logic lower_column_strobe_n_o,
  output logic wait_o,
  output logic refresh_mode_out_o
);
  import dcrs_pkg::*;

  initial begin
    if (REF_ACTIVE_CLKS >= REF_CPU_CLKS || REF_ACTIVE_CLKS < 1) begin
      $error("dcrs_sequencer: refresh clock split not servable");
    end
    if (REF_ACTIVE_CLKS > (1 << REF_CNT_W)) begin
      $error("dcrs_sequencer: refresh counter too narrow");
    end
  end

  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins_s;
  logic strobe_s;
  logic req_s;
  logic hi_byte_s;
  logic addr_lsb_s;
  logic ext_wait_s;
  logic cpu_s;
  logic cs_s;
  logic slow_s;

  // Pins pass two flops before use
  assign pins_raw = {cycle_start_strobe_n_i, forced_refresh_request_i, high_byte_enable_i,
                     low_address_bit_i, external_wait_in_i, cpu_system_clock_i,
                     chip_select_i, one_wait_select_n_i};

  dcrs_sync #(
    .W(PIN_W),
    .RST_VAL(8'h80)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(pins_raw),
    .sync_o(pins_s)
  );

  assign strobe_s = pins_s[7];
  assign req_s = pins_s[6];
  assign hi_byte_s = pins_s[5];
  assign addr_lsb_s = pins_s[4];
  assign ext_wait_s = pins_s[3];
  assign cpu_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign slow_s = ~pins_s[0];

  dcrs_state_t state_q;
  dcrs_state_t state_d;
  logic strobe_prev_q;
  logic strobe_prev_d;
  logic cpu_prev_q;
  logic cpu_prev_d;
  logic [REF_CNT_W-1:0] ref_cnt_q;
  logic [REF_CNT_W-1:0] ref_cnt_d;
  logic upper_n_q;
  logic upper_n_d;
  logic lower_n_q;
  logic lower_n_d;
  logic wait_q;
  logic wait_d;
  logic ref_mode_q;
  logic ref_mode_d;
  logic cycle_start;
  logic cpu_edge;

  assign cycle_start = strobe_prev_q & ~strobe_s;
  assign cpu_edge = cpu_s & ~cpu_prev_q;

  always_comb begin
    state_d = state_q;
    ref_cnt_d = ref_cnt_q;
    strobe_prev_d = strobe_s;
    cpu_prev_d = cpu_s;
    unique case (state_q)
      DCRS_IDLE: begin
        // Idle leaves only on cycle start or aligned refresh
        if (cycle_start) begin
          if (!cs_s) begin
            state_d = DCRS_HIDDEN;
          end else begin
            state_d = DCRS_ROW;
          end
        end else if (req_s && strobe_s && cpu_s) begin
          state_d = DCRS_REFRESH;
          ref_cnt_d = REF_CNT_RST;
        end
      end
      DCRS_ROW: begin
        // Row latched, column address settles
        if (slow_s) begin
          state_d = DCRS_SLOW;
        end else begin
          state_d = DCRS_COL;
        end
      end
      DCRS_SLOW: begin
        state_d = DCRS_COL;
      end
      DCRS_COL, DCRS_HIDDEN: begin
        if (strobe_s) begin
          state_d = DCRS_IDLE;
        end
      end
      DCRS_REFRESH: begin
        // Keep a held start pending
        strobe_prev_d = strobe_prev_q;
        if (cpu_edge) begin
          if (ref_cnt_q == REF_CNT_LAST) begin
            state_d = DCRS_PRECH;
          end else begin
            ref_cnt_d = ref_cnt_q + REF_CNT_ONE;
          end
        end
      end
      DCRS_PRECH: begin
        strobe_prev_d = strobe_prev_q;
        if (cpu_edge) begin
          state_d = DCRS_IDLE;
        end
      end
      default: begin
        state_d = DCRS_IDLE;
      end
    endcase
  end

  always_comb begin
    // Byte-wise column strobes
    upper_n_d = ~((state_d == DCRS_COL) & hi_byte_s);
    lower_n_d = ~((state_d == DCRS_COL) & ~addr_lsb_s);
    ref_mode_d = (state_d == DCRS_REFRESH);
    // Wait covers slow cycles, forced refresh, precharge and the external wait
    wait_d = (state_d == DCRS_SLOW) | (state_d == DCRS_REFRESH) | (state_d == DCRS_PRECH)
             | ext_wait_s;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= DCRS_IDLE;
      ref_cnt_q <= REF_CNT_RST;
      strobe_prev_q <= 1'b1;
      cpu_prev_q <= 1'b0;
      upper_n_q <= 1'b1;
      lower_n_q <= 1'b1;
      wait_q <= 1'b0;
      ref_mode_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ref_cnt_q <= ref_cnt_d;
      strobe_prev_q <= strobe_prev_d;
      cpu_prev_q <= cpu_prev_d;
      upper_n_q <= upper_n_d;
      lower_n_q <= lower_n_d;
      wait_q <= wait_d;
      ref_mode_q <= ref_mode_d;
    end
  end

  assign upper_column_strobe_n_o = upper_n_q;
  assign lower_column_strobe_n_o = lower_n_q;
  assign wait_o = wait_q;
  assign refresh_mode_out_o = ref_mode_q;

  default clocking dcrs_cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  col_after_row_a: assert property ($fell(upper_n_q) |->
    $past(state_q) inside {DCRS_ROW, DCRS_SLOW})
    else $error("column strobe without row phase");
  slow_one_wait_a: assert property (
    (state_q == DCRS_ROW && slow_s) |=> state_q == DCRS_SLOW ##1 state_q == DCRS_COL)
    else $error("slow cycle wait count wrong");
  fast_no_wait_a: assert property (
    (state_q == DCRS_ROW && !slow_s && !ext_wait_s) |=> state_q == DCRS_COL && !wait_q)
    else $error("fast cycle got a wait");
  ext_wait_a: assert property (ext_wait_s |=> wait_q)
    else $error("external wait not merged");
  hidden_quiet_a: assert property ((state_q == DCRS_HIDDEN) |->
    upper_n_q && lower_n_q && !ref_mode_q)
    else $error("activity during hidden refresh");
  ref_start_a: assert property (
    (state_q == DCRS_IDLE && !cycle_start && req_s && strobe_s && cpu_s)
    |=> state_q == DCRS_REFRESH && ref_cnt_q == REF_CNT_RST)
    else $error("forced refresh not started");
  cycle_first_a: assert property ((state_q == DCRS_COL) |=>
    state_q inside {DCRS_COL, DCRS_IDLE})
    else $error("cycle cut short by refresh");
  mode_wait_a: assert property (ref_mode_q |-> wait_q)
    else $error("refresh mode without wait");
  prech_wait_a: assert property (
    (state_q == DCRS_PRECH && !cpu_edge) |=> wait_q && !ref_mode_q)
    else $error("precharge released early");
  ref_len_a: assert property (
    (state_q == DCRS_REFRESH && cpu_edge && ref_cnt_q == REF_CNT_LAST) |=> state_q == DCRS_PRECH)
    else $error("refresh phase length wrong");
  slow_wait_now_a: assert property (
    (state_q == DCRS_ROW && slow_s) |=> wait_q)
    else $error("slow wait late");

  fast_cycle_c: cover property (state_q == DCRS_ROW ##1 state_q == DCRS_COL);
  slow_cycle_c: cover property (state_q == DCRS_SLOW ##1 state_q == DCRS_COL);
  hidden_c: cover property (state_q == DCRS_HIDDEN);
  forced_c: cover property (state_q == DCRS_PRECH ##1 state_q == DCRS_IDLE);
endmodule : dcrs_sequencer

// ==== shared/dcrs_pkg.sv ====
package dcrs_pkg;
  // Processor clocks spent in one forced refresh
  localparam int unsigned REF_CPU_CLKS = 4;
  // Of those, clocks with refresh mode asserted
  localparam int unsigned REF_ACTIVE_CLKS = 3;
  localparam int unsigned REF_CNT_W = 2;
  localparam logic [REF_CNT_W-1:0] REF_CNT_RST = 2'h0;
  localparam logic [REF_CNT_W-1:0] REF_CNT_ONE = 2'h1;
  localparam logic [REF_CNT_W-1:0] REF_CNT_LAST = 2'(REF_ACTIVE_CLKS - 1);
  // Pin group width through the synchroniser
  localparam int unsigned PIN_W = 8;

  typedef enum logic [3:0] {
    DCRS_IDLE,
    DCRS_ROW,
    DCRS_SLOW,
    DCRS_COL,
    DCRS_HIDDEN,
    DCRS_REFRESH,
    DCRS_PRECH
  } dcrs_state_t;
endpackage : dcrs_pkg

// ==== hdl/dcrs_sync.sv ====
module dcrs_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  initial begin
    if (W < 1) begin
      $error("dcrs_sync: W must be at least 1");
    end
  end

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule : dcrs_sync

// ==== tb/dcrs_partner.sv ====
module dcrs_partner (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic want_refresh_i,
  input wire logic refresh_mode_i,
  output logic cpu_clk_o,
  output logic refresh_req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] div_q;
  // Processor clock at a quarter of the fast clock
  // Controller refreshes unselected cycles by itself
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      div_q <= 2'h0;
      cpu_clk_o <= 1'b0;
      refresh_req_o <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      cpu_clk_o <= div_q[1];
      if (want_refresh_i) begin
        refresh_req_o <= 1'b1;
      end else if (refresh_mode_i) begin
        refresh_req_o <= 1'b0;
      end
    end
  end
endmodule : dcrs_partner

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, strobe_n = 1, want = 0, hi_byte = 0, addr_lsb = 0;
  logic ext_wait = 0, cs = 0, slow_n = 1, cpu_clk, ref_req, ucas_n, lcas_n, wait_s, ref_mode;
  logic gu, gl;
  int n_errors = 0, checks_done = 0, cyc = 0, nw, fc, len;
  always #20 mclk = ~mclk;
  dcrs_partner partner (.mclk_i(mclk), .rst_i(rst), .want_refresh_i(want),
    .refresh_mode_i(ref_mode), .cpu_clk_o(cpu_clk), .refresh_req_o(ref_req));
  dcrs_sequencer dut (.mclk_i(mclk), .rst_i(rst), .cycle_start_strobe_n_i(strobe_n),
    .forced_refresh_request_i(ref_req), .high_byte_enable_i(hi_byte),
    .low_address_bit_i(addr_lsb),
    .external_wait_in_i(ext_wait), .cpu_system_clock_i(cpu_clk), .chip_select_i(cs),
    .one_wait_select_n_i(slow_n), .upper_column_strobe_n_o(ucas_n),
    .lower_column_strobe_n_o(lcas_n), .wait_o(wait_s), .refresh_mode_out_o(ref_mode));
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk
  // One memory cycle; counts waits and the first strobe slot
  task automatic run_cycle(input logic sel, sl, h, a);
    nw = 0;
    fc = 99;
    gu = 0;
    gl = 0;
    strobe_n <= 1'b0;
    cs <= sel;
    slow_n <= sl;
    hi_byte <= h;
    addr_lsb <= a;
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk);
      #1;
      if (wait_s === 1'b1) nw++;
      if (fc == 99 && (ucas_n === 1'b0 || lcas_n === 1'b0)) fc = i;
      gu |= (ucas_n === 1'b0);
      gl |= (lcas_n === 1'b0);
    end
    @(posedge mclk);
    strobe_n <= 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk("strobes idle", 1, ucas_n & lcas_n);
    @(posedge mclk);
  endtask : run_cycle
  task automatic fast_cycles();
    for (int k = 0; k < 4; k++) begin
      run_cycle(1, 1, k[1], k[0]);
      chk("upper strobe", 8'(k[1]), gu);
      chk("lower strobe", 8'(!k[0]), gl);
      chk("fast waits", 0, 8'(nw));
      chk("fast strobe slot", 1, (k == 1) ? (fc == 99) : (fc inside {3, 4}));
    end
  endtask : fast_cycles
  task automatic slow_cycle();
    run_cycle(1, 0, 1, 1);
    chk("slow upper", 1, gu);
    chk("slow lower", 0, gl);
    chk("slow waits", 1, 8'(nw));
    chk("slow strobe slot", 1, fc inside {4, 5});
  endtask : slow_cycle
  task automatic unselected_cycle();
    run_cycle(0, 1, 1, 0);
    chk("hidden strobes", 0, gu | gl);
    chk("hidden waits", 0, 8'(nw));
  endtask : unselected_cycle
  task automatic external_wait();
    ext_wait <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("merged wait", 1, wait_s);
    @(posedge mclk);
    ext_wait <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("merged wait off", 0, wait_s);
    @(posedge mclk);
  endtask : external_wait
  task automatic forced_refresh();
    strobe_n <= 1'b0;
    cs <= 1'b1;
    want <= 1'b1;
    @(posedge mclk);
    want <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk("refresh in cycle", 0, ref_mode);
    @(posedge mclk);
    strobe_n <= 1'b1;
    len = 0;
    while (ref_mode !== 1'b1 && len < 20) begin
      @(posedge mclk);
      #1;
      len++;
    end
    chk("refresh wait", 1, wait_s);
    chk("refresh strobes", 1, ucas_n & lcas_n);
    len = 0;
    nw = 0;
    while (wait_s === 1'b1 && nw < 30) begin
      if (ref_mode === 1'b1) len++;
      nw++;
      @(posedge mclk);
      #1;
    end
    chk("refresh mode span", 1, len inside {[9:13]});
    chk("refresh total span", 1, nw inside {[13:17]});
    @(posedge mclk);
  endtask : forced_refresh
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    fast_cycles();
    slow_cycle();
    unselected_cycle();
    external_wait();
    forced_refresh();
    give_verdict();
  end
endmodule : testbench
